/* hdl/dbt_defines.svh */
// Operation
// - mode 0 runs both bytes as independent 8-bit timers, high on 2-cycle ticks, low on 2-cycle ticks or events
// - low prescaler input is 2-cycle ticks or events in modes 0/2, every cycle otherwise
// - high prescaler input: 2 cycles, 1 cycle, low match, or low PWM period
// - low counter counts external events in modes 0 and 2 when an event pin is selected as source
// - prescaler divides by 1 when disabled, else 2 to 256 by 3-bit code
// - prescaler clears when its counter stops or its byte reset occurs
// - low byte runs on control bit 6, high byte on control bit 7
// - counter increments on prescaler output and matches against its match buffer
// - low counter clears when stopped or on match in modes 0 and 2
// - high counter clears when stopped or on match in modes 0, 2 and 3
// - match buffer follows data while stopped, reloads at count zero while running
// - output high while stopped, low while running with match data FFH
// - output mode 0 makes low output toggle on each low match
// - output mode 1 makes low output PWM: low on overflow, high on match
// - output mode 0 or length 1 makes high output toggle on each high match
// - output mode 1 with length 0 makes high output PWM
// - PWM period is 256 prescale counts, low time is match plus one counts
// - mode 2 clocks the high prescaler once per low period
// - each byte requests an interrupt at end of its period when enabled
// - match flag set when running counter reaches zero, cleared only by software
// - flag and enable both one request the shared timer interrupt
// - prescaler change while running takes effect at match buffer reload
`ifndef DBT_DEFINES_SVH
`define DBT_DEFINES_SVH
`define DBT_ADDR_CONTROL 16'hfe18
`define DBT_ADDR_PRESCALE 16'hfe19
`define DBT_ADDR_LOW_COUNT 16'hfe1a
`define DBT_ADDR_HIGH_COUNT 16'hfe1b
`define DBT_ADDR_LOW_MATCH 16'hfe1c
`define DBT_ADDR_HIGH_MATCH 16'hfe1d
`define DBT_BIT_HIGH_RUN 7
`define DBT_BIT_LOW_RUN 6
`define DBT_BIT_LENGTH 5
`define DBT_BIT_OUT_MODE 4
`define DBT_BIT_HIGH_FLAG 3
`define DBT_BIT_HIGH_IE 2
`define DBT_BIT_LOW_FLAG 1
`define DBT_BIT_LOW_IE 0
`define DBT_PRE_ENABLE_BIT 3
`define DBT_REG_RESET 8'h00
`define DBT_MATCH_ALL_ONES 8'hff
`endif

/* hdl/dbt_pkg.sv */
package dbt_pkg;
  // length bit in the high position, output-mode bit low
  typedef enum logic [1:0] {
    DBT_MODE_TOGGLE8 = 2'b00,
    DBT_MODE_PWM8 = 2'b01,
    DBT_MODE_CASCADE = 2'b10,
    DBT_MODE_LOW_PWM16 = 2'b11
  } dbt_mode_t;
endpackage : dbt_pkg

/* hdl/dbt_byte_timer.sv */
`timescale 1ns/1ps
`include "dbt_defines.svh"
// one byte lane: prescaler, counter, match buffer and output pin
module dbt_byte_timer #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // control
  input wire logic run,
  input wire logic tickIn,
  input wire logic [3:0] preCfg,
  input wire logic [WIDTH-1:0] matchData,
  input wire logic clearOnMatch,
  input wire logic pwmMode,
  // status
  output logic [WIDTH-1:0] count,
  output logic matchHit,
  output logic reachZero,
  output logic overflow,
  output logic waveOut
);
  logic [WIDTH-1:0] preCnt_q;
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] buf_q;
  logic [3:0] preAct_q;
  logic wave_q;
  logic [WIDTH-1:0] preLimit;
  logic preOut;
  logic byteClear;
  logic wrapLast;

  // last prescaler state: 2^(code+1)-1 when enabled, 0 otherwise
  always_comb begin
    if (preAct_q[`DBT_PRE_ENABLE_BIT]) begin
      preLimit = WIDTH'((9'd2 << preAct_q[2:0]) - 9'd1);
    end else begin
      preLimit = '0;
    end
  end

  assign preOut = run && tickIn && (preCnt_q == preLimit);
  assign matchHit = run && (count_q == buf_q);
  assign wrapLast = count_q == {WIDTH{1'b1}};
  assign overflow = preOut && wrapLast;
  // byte reset: the counting step that lands on zero
  assign byteClear = preOut && ((clearOnMatch && matchHit) || wrapLast);
  // pulse on the step into zero, so flags see one event per period
  assign reachZero = byteClear;
  assign count = count_q;

  // prescaler divider
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !run || byteClear) begin
      preCnt_q <= '0;
    end else if (tickIn) begin
      preCnt_q <= (preCnt_q == preLimit) ? '0 : preCnt_q + 1'b1;
    end
  end

  // counter; stopped byte sits at zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !run) begin
      count_q <= '0;
    end else if (preOut) begin
      count_q <= (clearOnMatch && matchHit) ? '0 : count_q + 1'b1;
    end
  end

  // shadow match and prescale settings swap together at count zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      buf_q <= '0;
      preAct_q <= '0;
    end else if (!run || byteClear) begin
      buf_q <= matchData;
      preAct_q <= preCfg;
    end
  end

  // output: toggle on match, or PWM low on overflow and high on match
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !run) begin
      wave_q <= 1'b0;
    end else if (pwmMode) begin
      if (overflow) begin
        wave_q <= 1'b0;
      end else if (preOut && matchHit) begin
        wave_q <= 1'b1;
      end
    end else if (preOut && matchHit) begin
      wave_q <= ~wave_q;
    end
  end

  // forced levels take precedence; reset leaves the pin high
  always_comb begin
    if (!run) begin
      waveOut = 1'b1;
    end else if (matchData == `DBT_MATCH_ALL_ONES) begin
      waveOut = 1'b0;
    end else begin
      waveOut = wave_q;
    end
  end
endmodule : dbt_byte_timer

/* hdl/dbt_timer_unit.sv */
`timescale 1ns/1ps
`include "dbt_defines.svh"
// dual byte timer with PWM and toggle outputs
module dbt_timer_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // external event source
  input wire logic extEventIn,
  input wire logic extEventSelect,
  // outputs
  output logic lowWaveOut,
  output logic highWaveOut,
  output logic timerIrq
);
  logic [7:0] control_q;
  logic [7:0] prescale_q;
  logic [7:0] lowMatch_q;
  logic [7:0] highMatch_q;
  logic [7:0] rdData_q;
  logic evSync1_q;
  logic evSync2_q;
  logic evPrev_q;
  logic evPulse;
  logic halfTick_q;
  dbt_pkg::dbt_mode_t mode;
  logic lowRun;
  logic highRun;
  logic lowTick;
  logic highTick;
  logic lowClrMatch;
  logic highClrMatch;
  logic highPwm;
  logic [7:0] lowCount;
  logic [7:0] highCount;
  logic lowZero;
  logic highZero;
  logic lowOvf;

  assign mode = dbt_pkg::dbt_mode_t'({control_q[`DBT_BIT_LENGTH], control_q[`DBT_BIT_OUT_MODE]});
  assign lowRun = control_q[`DBT_BIT_LOW_RUN];
  assign highRun = control_q[`DBT_BIT_HIGH_RUN];

  // two-flop synchroniser then edge detect on the second flop only
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      evSync1_q <= 1'b0;
      evSync2_q <= 1'b0;
      evPrev_q <= 1'b0;
    end else begin
      evSync1_q <= extEventIn;
      evSync2_q <= evSync1_q;
      evPrev_q <= evSync2_q;
    end
  end
  assign evPulse = evSync2_q && !evPrev_q;

  // free-running half-rate tick shared by both bytes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      halfTick_q <= 1'b0;
    end else begin
      halfTick_q <= ~halfTick_q;
    end
  end

  // low count source; event source in PWM modes is undefined use, so ignored there
  always_comb begin
    case (mode)
      dbt_pkg::DBT_MODE_TOGGLE8, dbt_pkg::DBT_MODE_CASCADE: begin
        lowTick = extEventSelect ? evPulse : halfTick_q;
      end
      default: begin
        lowTick = 1'b1;
      end
    endcase
  end

  // high source: low match in cascade, low PWM wrap in mode 3
  always_comb begin
    case (mode)
      dbt_pkg::DBT_MODE_TOGGLE8: highTick = halfTick_q;
      dbt_pkg::DBT_MODE_PWM8: highTick = 1'b1;
      dbt_pkg::DBT_MODE_CASCADE: highTick = lowRun && lowZero;
      dbt_pkg::DBT_MODE_LOW_PWM16: highTick = lowRun && lowOvf;
      default: highTick = 1'b0;
    endcase
  end

  assign lowClrMatch = !control_q[`DBT_BIT_OUT_MODE];
  assign highClrMatch = (mode != dbt_pkg::DBT_MODE_PWM8);
  assign highPwm = (mode == dbt_pkg::DBT_MODE_PWM8);

  dbt_byte_timer #(
    .WIDTH(8)
  ) lowByte (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(lowRun),
    .tickIn(lowTick),
    .preCfg(prescale_q[3:0]),
    .matchData(lowMatch_q),
    .clearOnMatch(lowClrMatch),
    .pwmMode(control_q[`DBT_BIT_OUT_MODE]),
    .count(lowCount),
    .matchHit(), // the step pulses carry all the match news the top needs
    .reachZero(lowZero),
    .overflow(lowOvf),
    .waveOut(lowWaveOut)
  );

  dbt_byte_timer #(
    .WIDTH(8)
  ) highByte (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(highRun),
    .tickIn(highTick),
    .preCfg(prescale_q[7:4]),
    .matchData(highMatch_q),
    .clearOnMatch(highClrMatch),
    .pwmMode(highPwm),
    .count(highCount),
    .matchHit(),
    .reachZero(highZero),
    .overflow(), // nothing sits above the high byte
    .waveOut(highWaveOut)
  );

  // control register; hardware flag set wins over a software clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      control_q <= `DBT_REG_RESET;
    end else begin
      if (regWrite && regAddr == `DBT_ADDR_CONTROL) begin
        control_q <= regWrData;
      end
      if (lowZero) begin
        control_q[`DBT_BIT_LOW_FLAG] <= 1'b1;
      end
      if (highZero) begin
        control_q[`DBT_BIT_HIGH_FLAG] <= 1'b1;
      end
    end
  end

  // prescale and match data registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prescale_q <= `DBT_REG_RESET;
      lowMatch_q <= `DBT_REG_RESET;
      highMatch_q <= `DBT_REG_RESET;
    end else if (regWrite) begin
      case (regAddr)
        `DBT_ADDR_PRESCALE: prescale_q <= regWrData;
        `DBT_ADDR_LOW_MATCH: lowMatch_q <= regWrData;
        `DBT_ADDR_HIGH_MATCH: highMatch_q <= regWrData;
        default: ;
      endcase
    end
  end

  // read data registered, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdData_q <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `DBT_ADDR_CONTROL: rdData_q <= control_q;
        `DBT_ADDR_PRESCALE: rdData_q <= prescale_q;
        `DBT_ADDR_LOW_COUNT: rdData_q <= lowCount;
        `DBT_ADDR_HIGH_COUNT: rdData_q <= highCount;
        `DBT_ADDR_LOW_MATCH: rdData_q <= lowMatch_q;
        `DBT_ADDR_HIGH_MATCH: rdData_q <= highMatch_q;
        default: rdData_q <= 8'h00;
      endcase
    end else begin
      rdData_q <= 8'h00;
    end
  end
  assign regRdData = rdData_q;

  // shared request line, combinational from flags and enables
  assign timerIrq = (control_q[`DBT_BIT_LOW_FLAG] && control_q[`DBT_BIT_LOW_IE]) ||
                    (control_q[`DBT_BIT_HIGH_FLAG] && control_q[`DBT_BIT_HIGH_IE]);
endmodule : dbt_timer_unit

/* verif/dbt_timer_unit_asserts.sv */
`timescale 1ns/1ps
module dbt_timer_unit_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // events and outputs
  input wire logic extEventIn,
  input wire logic extEventSelect,
  input wire logic lowWaveOut,
  input wire logic highWaveOut,
  input wire logic timerIrq
);
  logic [1:0] runQ;
  logic [7:0] lowMdQ;
  logic [7:0] highMdQ;
  logic ctlWr;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // control writes only, so flags raised by hardware never look like software
  assign ctlWr = regWrite && regAddr == 16'hfe18;
  // shadow of run bits and match data, lands on the same edge as the real registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      runQ <= 2'h0;
      lowMdQ <= 8'h00;
      highMdQ <= 8'h00;
    end else if (regWrite) begin
      if (regAddr == 16'hfe18) runQ <= regWrData[7:6];
      if (regAddr == 16'hfe1c) lowMdQ <= regWrData;
      if (regAddr == 16'hfe1d) highMdQ <= regWrData;
    end
  end
  a_stop_low: assert property (!runQ[0] |-> lowWaveOut)
    else $error("low output not high while stopped");
  a_stop_high: assert property (!runQ[1] |-> highWaveOut)
    else $error("high output not high while stopped");
  a_ffh_low: assert property (runQ[0] && lowMdQ == 8'hff |-> !lowWaveOut)
    else $error("low output not low with all-ones match");
  a_ffh_high: assert property (runQ[1] && highMdQ == 8'hff |-> !highWaveOut)
    else $error("high output not low with all-ones match");
  a_irq_set: assert property (ctlWr && (regWrData[1] && regWrData[0] || regWrData[3] && regWrData[2])
    |=> timerIrq)
    else $error("request missing with flag and enable set");
  a_irq_off: assert property (ctlWr && !regWrData[0] && !regWrData[2] |=> !timerIrq)
    else $error("request present with enables clear");
  a_flag_hold: assert property (timerIrq && !ctlWr |=> timerIrq)
    else $error("request dropped without software write");
  a_rd_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data not zero outside read slot");
  a_rd_unmapped: assert property (regRead && (regAddr < 16'hfe18 || regAddr > 16'hfe1d) |=> regRdData == 8'h00)
    else $error("unmapped read returned nonzero");
  a_reset_out: assert property ($fell(sys_rst) |-> lowWaveOut && highWaveOut && !timerIrq)
    else $error("outputs wrong after reset");
endmodule : dbt_timer_unit_asserts
bind dbt_timer_unit dbt_timer_unit_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .extEventIn(extEventIn), .extEventSelect(extEventSelect), .lowWaveOut(lowWaveOut),
  .highWaveOut(highWaveOut), .timerIrq(timerIrq));

/* verif/dbt_timer_unit_test.sv */
`timescale 1ns/1ps
module dbt_timer_unit_test;
  logic clk_sys, sys_rst, regWrite, regRead, extEventIn, extEventSelect;
  logic [15:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic lowWaveOut, highWaveOut, timerIrq;
  int bad_count, compares, cycles, seed, m, hm, n, lo, hi;
  dbt_timer_unit DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .extEventIn(extEventIn),
    .extEventSelect(extEventSelect), .lowWaveOut(lowWaveOut), .highWaveOut(highWaveOut), .timerIrq(timerIrq));
  // 50 MHz cycle clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic test_done;
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  // bus cycles: one strobe cycle each, read data taken in the following cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask : rd
  // model of the prescale count for a 4-bit enable+code field
  function automatic int pc(input logic [3:0] c);
    return c[3] ? 2 << c[2:0] : 1;
  endfunction : pc
  // cycles between two output changes, sampled on the falling edge to stay off the update edge
  task automatic gap(input bit h, output int n);
    logic v;
    int k;
    @(negedge clk_sys);
    v = h ? highWaveOut : lowWaveOut;
    k = 0;
    n = 0;
    while ((h ? highWaveOut : lowWaveOut) === v && k < 9000) begin @(negedge clk_sys); k++; end
    v = h ? highWaveOut : lowWaveOut;
    while ((h ? highWaveOut : lowWaveOut) === v && n < 9000) begin @(negedge clk_sys); n++; end
  endtask : gap
  // one event, long enough for the synchroniser, then settle
  task automatic pulse;
    @(posedge clk_sys) extEventIn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    extEventIn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : pulse
  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      test_done;
    end
  end
  initial begin
    seed = 32'h667a;
    {regAddr, regWrData, regWrite, regRead, extEventIn, extEventSelect} = '0;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int a = 0; a < 6; a++) rd(16'hfe18 + 16'(a), 8'h00);
    chk({lowWaveOut, highWaveOut, timerIrq}, 3'b110);
    wr(16'hfe1a, 8'h55);
    wr(16'hfe1c, 8'ha5);
    rd(16'hfe1a, 8'h00);
    rd(16'hfe1c, 8'ha5);
    rd(16'hfe20, 8'h00);
    wr(16'hfe18, 8'h03);
    rd(16'hfe18, 8'h03);
    // mode 0: toggle interval across every prescale code
    for (int k = 0; k < 8; k++) begin
      m = $random(seed) & 3;
      wr(16'hfe18, 8'h00);
      wr(16'hfe1c, 8'(m));
      wr(16'hfe19, 8'(8 | k));
      wr(16'hfe18, 8'h45);
      gap(0, n);
      chk(n, (m + 1) * pc(4'(8 | k)) * 2);
    end
    rd(16'hfe18, 8'h47);
    hm = $random(seed) & 3;
    wr(16'hfe18, 8'h00);
    wr(16'hfe1d, 8'(hm));
    wr(16'hfe19, 8'h90);
    wr(16'hfe18, 8'he0);
    gap(1, n);
    chk(n, (hm + 1) * 4 * (m + 1) * 2);
    wr(16'hfe18, 8'h00);
    wr(16'hfe19, 8'h00);
    wr(16'hfe18, 8'hf0);
    gap(1, n);
    chk(n, (hm + 1) * 256);
    wr(16'hfe18, 8'h00);
    wr(16'hfe18, 8'h80);
    gap(1, n);
    chk(n, (hm + 1) * 2);
    // mode 1: match data changed while running reloads at the wrap
    wr(16'hfe18, 8'h00);
    wr(16'hfe19, 8'h88);
    wr(16'hfe18, 8'hd0);
    for (int k = 0; k < 4; k++) begin
      m = (k == 3) ? 255 : $random(seed) & 255;
      wr(16'hfe1c, 8'(m));
      wr(16'hfe1d, 8'(m));
      repeat (600) @(negedge clk_sys);
      lo = 0;
      hi = 0;
      repeat (512) begin
        @(negedge clk_sys);
        lo += (lowWaveOut === 1'b0);
        hi += (highWaveOut === 1'b0);
      end
      chk(lo, (m + 1) * 2);
      chk(hi, (m + 1) * 2);
    end
    // event counting: free ticks must not advance the low byte
    wr(16'hfe18, 8'h00);
    extEventSelect <= 1'b1;
    wr(16'hfe1c, 8'h02);
    wr(16'hfe19, 8'h00);
    wr(16'hfe18, 8'h41);
    for (int e = 1; e <= 3; e++) begin
      pulse;
      chk(lowWaveOut, e == 3);
    end
    rd(16'hfe18, 8'h43);
    wr(16'hfe18, 8'h41);
    rd(16'hfe18, 8'h41);
    @(posedge clk_sys);
    extEventSelect <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(16'hfe1c, 8'h00);
    test_done;
  end
endmodule : dbt_timer_unit_test
